// file: hdl/dtc_pkg.sv
// Package: debug control register layout, reset values, run states
package dtc_pkg;
  localparam int DATA_W = 8;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ARM = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_BRK = 4;
  localparam int BIT_A_DIR_VAL = 3;
  localparam int BIT_A_DIR_CHK = 2;
  localparam int BIT_B_DIR_VAL = 1;
  localparam int BIT_B_DIR_CHK = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FILL_LAST = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_FILL = 3'b100
  } dtc_run_t;
endpackage : dtc_pkg

// file: hdl/dtc_dir_cmp.sv
// Address comparator with optional read/write direction qualifier
module dtc_dir_cmp (
  input wire logic [15:0] cmp_value,
  input wire logic [15:0] bus_addr,
  input wire logic bus_read,
  input wire logic dir_check,
  input wire logic dir_value,
  output logic hit
);
  import dtc_pkg::*;
  // Check set: value 1 = reads only, 0 = writes only; check clear: address alone
  assign hit = (cmp_value == bus_addr) && (!dir_check || (dir_value == bus_read));
endmodule : dtc_dir_cmp

// file: hdl/dtc_cmp_regs.sv
// Comparator value registers, writable only while disarmed
module dtc_cmp_regs (
  input wire logic clock,
  input wire logic srst,
  input wire logic armed,
  input wire logic wr_a,
  input wire logic wr_b,
  input wire logic [15:0] wr_data,
  output logic [15:0] cmp_a,
  output logic [15:0] cmp_b
);
  import dtc_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } dtc_cmp_state_t;
  dtc_cmp_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!armed && wr_a) begin
      s_d.a = wr_data;
    end
    if (!armed && wr_b) begin
      s_d.b = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{a: CMP_RESET, b: CMP_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign cmp_a = s_q.a;
  assign cmp_b = s_q.b;
endmodule : dtc_cmp_regs

// file: hdl/dtc_debug_trigger_control.sv
// Debug trigger control: control register, arming, break request timing

module dtc_debug_trigger_control (
  input wire logic clock,
  input wire logic srst,
  input wire logic secured,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic cmp_a_wr,
  input wire logic cmp_b_wr,
  input wire logic [15:0] cmp_wdata,
  output logic [15:0] cmp_a_value,
  output logic [15:0] cmp_b_value,
  input wire logic trigger_qualify_select,
  input wire logic begin_trace,
  input wire logic bus_valid,
  input wire logic [15:0] bus_addr,
  input wire logic bus_read,
  input wire logic opcode_executed,
  output logic capture_active_flag,
  output logic capture_store,
  output logic [15:0] capture_data,
  output logic break_force,
  output logic break_tag
);
  import dtc_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic active;
    dtc_run_t run;
    logic [3:0] fill;
    logic store;
    logic [15:0] data;
    logic brk_f;
    logic brk_t;
  } dtc_state_t;

  dtc_state_t s_q, s_d;
  logic hit_a;
  logic hit_b;
  logic raw_trig;
  logic trig;
  logic armed;
  logic unit_on;

  assign unit_on = s_q.ctrl[BIT_ENABLE];
  assign armed = s_q.ctrl[BIT_ARM] && unit_on;

  dtc_cmp_regs u_regs (
    .clock(clock),
    .srst(srst),
    .armed(s_q.ctrl[BIT_ARM]),
    .wr_a(cmp_a_wr),
    .wr_b(cmp_b_wr),
    .wr_data(cmp_wdata),
    .cmp_a(cmp_a_value),
    .cmp_b(cmp_b_value)
  );

  dtc_dir_cmp u_cmp_a (
    .cmp_value(cmp_a_value),
    .bus_addr(bus_addr),
    .bus_read(bus_read),
    .dir_check(s_q.ctrl[BIT_A_DIR_CHK]),
    .dir_value(s_q.ctrl[BIT_A_DIR_VAL]),
    .hit(hit_a)
  );

  dtc_dir_cmp u_cmp_b (
    .cmp_value(cmp_b_value),
    .bus_addr(bus_addr),
    .bus_read(bus_read),
    .dir_check(s_q.ctrl[BIT_B_DIR_CHK]),
    .dir_value(s_q.ctrl[BIT_B_DIR_VAL]),
    .hit(hit_b)
  );

  // Force and tag alike: any access, or only an executed opcode while the qualify select is set
  assign raw_trig = bus_valid && (hit_a || hit_b);
  assign trig = armed && raw_trig && (!trigger_qualify_select || opcode_executed);

  // Break pulse routed by kind; nothing raised while breaks are off
  function automatic logic [1:0] brk_kind(input logic [7:0] c, input logic fire);
    brk_kind = 2'b00;
    if (fire && c[BIT_BRK]) begin
      brk_kind = c[BIT_TAG] ? 2'b01 : 2'b10;
    end
  endfunction : brk_kind

  always_comb begin
    logic stop;
    logic done;
    logic fire;
    logic [1:0] bk;
    stop = 1'b0;
    done = 1'b0;
    fire = 1'b0;
    bk = 2'b00;
    s_d = s_q;
    s_d.store = 1'b0;
    s_d.brk_f = 1'b0;
    s_d.brk_t = 1'b0;

    case (s_q.run)
      ST_IDLE: begin
        if (armed) begin
          s_d.run = ST_WAIT;
          s_d.fill = 4'h0;
        end
      end
      ST_WAIT: begin
        // Break kind follows the tag bit only, never the qualify select
        if (!armed) begin
          stop = 1'b1;
        end else if (trig) begin
          if (begin_trace) begin
            s_d.run = ST_FILL;
            s_d.store = 1'b1;
            s_d.data = bus_addr;
            s_d.fill = 4'h1;
          end else begin
            s_d.store = 1'b1;
            s_d.data = bus_addr;
            fire = 1'b1;
            done = 1'b1;
          end
        end else if (raw_trig && !begin_trace) begin
          // End trace: circular storage until the trigger
          s_d.store = 1'b1;
          s_d.data = bus_addr;
        end
      end
      ST_FILL: begin
        if (!armed) begin
          stop = 1'b1;
        end else if (bus_valid) begin
          s_d.store = 1'b1;
          s_d.data = bus_addr;
          s_d.fill = s_q.fill + 4'h1;
          if (s_q.fill + 4'h1 == FILL_LAST) begin
            fire = 1'b1;
            done = 1'b1;
          end
        end
      end
      default: begin
        s_d.run = ST_IDLE;
      end
    endcase

    bk = brk_kind(s_q.ctrl, fire);
    s_d.brk_t = bk[0];
    s_d.brk_f = bk[1];

    if (done || stop) begin
      s_d.run = ST_IDLE;
      s_d.ctrl[BIT_ARM] = 1'b0;
      s_d.active = 1'b0;
    end

    // Software write lands last so a new arm wins over completion
    if (ctrl_wr) begin
      s_d.ctrl = ctrl_wdata;
      if (secured) begin
        s_d.ctrl[BIT_ENABLE] = 1'b0;
      end
      if (ctrl_wdata[BIT_ARM]) begin
        s_d.active = 1'b1;
      end
      if (!ctrl_wdata[BIT_ARM] || !s_d.ctrl[BIT_ENABLE]) begin
        s_d.active = 1'b0;
        s_d.run = ST_IDLE;
        s_d.store = 1'b0;
        s_d.brk_f = 1'b0;
        s_d.brk_t = 1'b0;
      end
    end
    if (secured) begin
      s_d.ctrl[BIT_ENABLE] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{ctrl: CTRL_RESET, active: 1'b0, run: ST_IDLE, fill: 4'h0,
               store: 1'b0, data: CMP_RESET, brk_f: 1'b0, brk_t: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ctrl_rdata = s_q.ctrl;
  assign capture_active_flag = s_q.active;
  assign capture_store = s_q.store;
  assign capture_data = s_q.data;
  assign break_force = s_q.brk_f;
  assign break_tag = s_q.brk_t;
endmodule : dtc_debug_trigger_control

// file: tb/dtc_checker.sv
// Checker: control register and break request properties
module dtc_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic secured,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic cmp_a_wr,
  input wire logic [15:0] cmp_a_value,
  input wire logic begin_trace,
  input wire logic capture_active_flag,
  input wire logic capture_store,
  input wire logic break_force,
  input wire logic break_tag
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  a_secure_en_low: assert property (secured |=> !ctrl_rdata[7])
    else $error("enable set while secured");
  a_write_readback: assert property (ctrl_wr && !secured && !ctrl_wdata[6]
    |=> ctrl_rdata == $past(ctrl_wdata)) else $error("write not kept");
  a_arm_sets_flag: assert property (ctrl_wr && !secured && ctrl_wdata[7:6] == 2'b11
    |=> capture_active_flag && ctrl_rdata[6]) else $error("flag not set");
  a_flag_with_arm: assert property (capture_active_flag |-> ctrl_rdata[6])
    else $error("flag without arm");
  a_stop_clears: assert property (ctrl_wr && !(ctrl_wdata[6] && ctrl_wdata[7])
    |=> !capture_active_flag) else $error("run not stopped");
  a_tag_kind: assert property (break_tag |-> $past(ctrl_rdata[5:4]) == 2'b11)
    else $error("bad tag break");
  a_force_kind: assert property (break_force |-> $past(ctrl_rdata[5:4]) == 2'b01)
    else $error("bad force break");
  a_end_break: assert property ((break_force || break_tag) && !$past(begin_trace)
    |-> capture_store) else $error("break without store");
  a_cmp_locked: assert property (ctrl_rdata[6] && cmp_a_wr |=> $stable(cmp_a_value))
    else $error("comparator written while armed");
  c_force: cover property (break_force);
  c_tag: cover property (break_tag);
  c_fill: cover property (begin_trace && break_force);
endmodule : dtc_checker

bind dtc_debug_trigger_control dtc_checker dtc_checker_inst (.*);

// file: tb/dtc_core_model.sv
// Core model: issues one bus access per call
module dtc_core_model (
  input wire logic clock,
  output logic bus_valid,
  output logic [15:0] bus_addr,
  output logic bus_read,
  output logic opcode_executed
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {bus_valid, bus_addr, bus_read, opcode_executed} = '0;
  task automatic access(input logic [15:0] a, input logic rd, input logic ex);
    @(negedge clock);
    {bus_valid, bus_addr, bus_read, opcode_executed} = {1'b1, a, rd, ex};
    @(negedge clock);
    // Released address and read lines show inverted junk, not the old value; valid and executed drop to 0
    {bus_valid, bus_addr, bus_read, opcode_executed} = {1'b0, ~a, ~rd, 1'b0};
  endtask : access
endmodule : dtc_core_model

// file: tb/tb_dtc_debug_trigger_control.sv
// Testbench: control register, arming, direction and break scenarios
module tb_dtc_debug_trigger_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, srst = 1, secured = 0, ctrl_wr = 0, cmp_a_wr = 0, cmp_b_wr = 0;
  logic trigger_qualify_select = 0, begin_trace = 0;
  logic [7:0] ctrl_wdata = 0, ctrl_rdata;
  logic [15:0] cmp_wdata = 0, cmp_a_value, cmp_b_value, bus_addr, capture_data;
  logic bus_valid, bus_read, opcode_executed, capture_active_flag;
  logic capture_store, break_force, break_tag;
  logic [27:0] t;
  int err_total = 0, n_compared = 0;
  // Control, address, then read, qualify, executed, trigger expected
  logic [27:0] tbl [11] = '{28'hd012341, 28'hf012349, 28'hc012341, 28'hdc12340,
    28'hdc12349, 28'hd812341, 28'hd143218, 28'hd143211, 28'hd343219, 28'hd012344,
    28'hd012347};
  dtc_debug_trigger_control dtc_debug_trigger_control_inst (.*);
  dtc_core_model dtc_core_model_inst (.*);
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    @(negedge clock);
    {ctrl_wr, ctrl_wdata} = {1'b1, d};
    @(negedge clock);
    ctrl_wr = 0;
  endtask : wr
  task automatic wrc(input logic a, input logic [15:0] d);
    @(negedge clock);
    {cmp_a_wr, cmp_b_wr, cmp_wdata} = {a, !a, d};
    @(negedge clock);
    {cmp_a_wr, cmp_b_wr} = 2'b00;
  endtask : wrc
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial forever #12.5 clock = ~clock;
  initial begin
    repeat (2) @(negedge clock);
    srst = 0;
    chk("ctrl", ctrl_rdata, 16'h0);
    wr(8'h3f);
    chk("ctrl", ctrl_rdata, 16'h3f);
    secured = 1;
    wr(8'h80);
    chk("en", ctrl_rdata[7], 16'h0);
    secured = 0;
    wrc(1, 16'h1234);
    wrc(0, 16'h4321);
    chk("cmpa", cmp_a_value, 16'h1234);
    chk("cmpb", cmp_b_value, 16'h4321);
    // Arm with the unit off: no run, no flag, no break
    wr(8'h50);
    chk("flag", capture_active_flag, 16'h0);
    dtc_core_model_inst.access(16'h1234, 0, 0);
    chk("force", break_force, 16'h0);
    wr(8'h00);
    foreach (tbl[i]) begin
      t = tbl[i];
      trigger_qualify_select = t[2];
      wr(t[27:20]);
      chk("flag", capture_active_flag, 16'h1);
      // Doubles as the arming delay
      wrc(1, 16'h5555);
      chk("cmpa", cmp_a_value, 16'h1234);
      dtc_core_model_inst.access(t[19:4], t[3], t[1]);
      chk("force", break_force, t[0] & t[24] & !t[25]);
      chk("tag", break_tag, t[0] & t[24] & t[25]);
      chk("flag", capture_active_flag, !t[0]);
      if (t[0]) chk("data", capture_data, t[19:4]);
      wr(8'h00);
      chk("flag", capture_active_flag, 16'h0);
    end
    {begin_trace, trigger_qualify_select} = 2'b10;
    wr(8'hd0);
    repeat (2) @(negedge clock);
    for (int j = 0; j < dtc_pkg::FIFO_DEPTH; j++) begin
      dtc_core_model_inst.access(16'h1234, 0, 0);
      chk("fill", break_force, j == dtc_pkg::FIFO_DEPTH - 1);
      chk("store", capture_store, 16'h1);
    end
    chk("flag", capture_active_flag, 16'h0);
    final_report();
  end
endmodule : tb_dtc_debug_trigger_control
